// ==== logic/oob_com_sequence_beacon.sv ====
// out-of-band sequence encoder/decoder with beacon comma detect
//
// Functional notes
// RULE1: each sequence is burst then idle
// RULE2: receiver classifies by idle length
// RULE3: wake idle is 106.7 ns
// RULE4: init and reset share 320 ns idle
// RULE5: report after four consecutive matching pairs
// RULE6: machines generate and decode the sequences
// RULE7: beacons are comma bursts with idle
// RULE8: beacon repeats between 30 kHz, 500 MHz
// RULE9: fabric logic formats beacon timing itself
// RULE10: beacon control uses phy-interface idle signals
// RULE11: raw comma is ten-bit 0011111010
// RULE12: unmatched idle restarts the repeat count
`timescale 1ns/100ps
module oob_com_sequence_beacon (
  input  wire logic              clk_sys_i,
  input  wire logic              rst_b_i,
  input  wire logic              tx_com_start_i,
  input  wire oob_pkg::com_kind_e tx_com_kind_i,
  input  wire logic              tx_elec_idle_i,
  output logic                   tx_elec_idle_o,
  output logic                   tx_com_burst_o,
  output logic                   tx_com_busy_o,
  output logic                   tx_com_done_o,
  input  wire logic              rx_elec_idle_i,
  input  wire logic [9:0]        rx_data_raw_i,
  output logic                   rx_elec_idle_o,
  output logic                   rx_comwake_o,
  output logic                   rx_cominit_o,
  output logic                   rx_comma_o
);
  import oob_pkg::*;

  oob_seq_if seq_bus ();

  logic              idle_meta_r;
  logic              idle_sync_r;
  logic              idle_prev_r;
  logic              seen_burst_r;
  logic [CNT_W-1:0]  idle_cnt_r;
  logic              rep_is_wake_r;
  logic [2:0]        rep_cnt_r;
  logic              idle_end;
  logic              idle_overrun;
  logic              is_wake;
  logic              is_com;
  logic              pair_ok;
  logic              pair_wake;
  logic              kind_change;
  logic              run_full;
  logic              report;

  // request path into the sequencer; a start while busy is ignored there
  assign seq_bus.start = tx_com_start_i;
  assign seq_bus.kind  = tx_com_kind_i;

  oob_tx_seq u_tx_seq (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .seq_if    (seq_bus.seq)
  );

  // RULE10: fabric idle request passes when no sequence runs
  // RULE9: beacon format left to fabric
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      tx_elec_idle_o <= 1'b1;
    end else begin
      tx_elec_idle_o <= seq_bus.busy ? !seq_bus.burst : tx_elec_idle_i;
    end
  end

  // burst flag registered beside the line drive so both move on one edge
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      tx_com_burst_o <= 1'b0;
    end else begin
      tx_com_burst_o <= seq_bus.burst;
    end
  end

  // busy for the whole sequence; the fabric waits for it to drop
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      tx_com_busy_o <= 1'b0;
    end else begin
      tx_com_busy_o <= seq_bus.busy;
    end
  end

  // completion pulse, high in the cycle busy falls
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      tx_com_done_o <= 1'b0;
    end else begin
      tx_com_done_o <= seq_bus.done;
    end
  end

  // squelch level comes from the analog front end, so two flops first
  // flops reset to idle, the quiet level, so release makes no false edge
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      idle_meta_r <= 1'b1;
      idle_sync_r <= 1'b1;
      idle_prev_r <= 1'b1;
    end else begin
      idle_meta_r <= rx_elec_idle_i;
      idle_sync_r <= idle_meta_r;
      idle_prev_r <= idle_sync_r;
    end
  end

  // RULE10: synchronised idle status back to fabric
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      rx_elec_idle_o <= 1'b1;
    end else begin
      rx_elec_idle_o <= idle_sync_r;
    end
  end

  // idle length counter, saturating so long quiet periods never wrap
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      idle_cnt_r <= '0;
    end else if (!idle_sync_r) begin
      idle_cnt_r <= '0;
    end else if (idle_cnt_r != '1) begin
      idle_cnt_r <= idle_cnt_r + 1'b1;
    end
  end

  // an idle counts only once a burst has preceded it
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      seen_burst_r <= 1'b0;
    end else if (!idle_sync_r) begin
      seen_burst_r <= 1'b1;
    end else if (idle_overrun) begin
      seen_burst_r <= 1'b0;
    end
  end

  // an idle ends on the first synchronised burst cycle after it
  // RULE2: classify the idle at its end
  // RULE3: wake window
  // RULE4: init and reset not separable
  assign idle_end     = idle_prev_r && !idle_sync_r && seen_burst_r;
  assign idle_overrun = idle_sync_r && seen_burst_r
                        && (idle_cnt_r == CNT_W'(COM_IDLE_CYC + IDLE_TOL_CYC + 1));
  assign is_wake      = idle_in_window(idle_cnt_r, WAKE_IDLE_CYC);
  assign is_com       = idle_in_window(idle_cnt_r, COM_IDLE_CYC);

  // a trailing idle that never ends closes the fourth pair of the run in progress
  assign pair_ok   = (idle_end && (is_wake || is_com))
                     || (idle_overrun && (rep_cnt_r == 3'(COM_VALID_REPEAT - 1)));
  assign pair_wake = idle_end ? is_wake : rep_is_wake_r;

  // decode steps: kind change, full run, and the report itself
  // a pair only counts toward a report when it matches the held run
  assign kind_change = (rep_cnt_r != '0) && (pair_wake != rep_is_wake_r);
  assign run_full    = (rep_cnt_r == 3'(COM_VALID_REPEAT - 1));
  assign report      = pair_ok && !kind_change && run_full;

  // RULE5: four consecutive matching pairs
  // RULE12: mismatch or bad idle restarts count
  // RULE6: receive decode machine
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      rep_cnt_r <= '0;
    end else if (pair_ok) begin
      if (kind_change) begin
        // a pair of the other kind opens a new run at one
        rep_cnt_r <= 3'd1;
      end else if (run_full) begin
        // full run is reported; the next one starts from zero
        rep_cnt_r <= '0;
      end else begin
        rep_cnt_r <= rep_cnt_r + 1'b1;
      end
    end else if (idle_end || idle_overrun) begin
      // idle outside both windows, or a quiet line, drops the run
      rep_cnt_r <= '0;
    end
  end

  // kind of the run being counted
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      rep_is_wake_r <= 1'b0;
    end else if (pair_ok) begin
      // held so a quiet fourth idle knows which kind it closes
      rep_is_wake_r <= pair_wake;
    end
  end

  // one-cycle report pulses; the fabric must take them on that edge
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      rx_comwake_o <= 1'b0;
      rx_cominit_o <= 1'b0;
    end else begin
      rx_comwake_o <= report && pair_wake;
      rx_cominit_o <= report && !pair_wake;
    end
  end

  // raw match with no decode, so a comma shows one edge after it arrives
  // RULE11: raw comma match
  // RULE7: commas form the beacon bursts
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      rx_comma_o <= 1'b0;
    end else begin
      rx_comma_o <= (rx_data_raw_i == COMMA_RAW);
    end
  end

endmodule // oob_com_sequence_beacon

// ==== logic/oob_pkg.sv ====
// shared constants and types for the out-of-band sequence block
package oob_pkg;

  // clock and timing figures
  localparam real CLK_PERIOD_NS = 10.0;
  localparam real WAKE_IDLE_NS  = 106.7;
  localparam real COM_IDLE_NS   = 320.0;
  localparam real BURST_NS      = 106.7;

  // idle and burst lengths in clock cycles, least times rounded up
  localparam int WAKE_IDLE_CYC = int'($ceil(WAKE_IDLE_NS / CLK_PERIOD_NS));
  localparam int COM_IDLE_CYC  = int'($ceil(COM_IDLE_NS / CLK_PERIOD_NS));
  localparam int BURST_CYC     = int'($ceil(BURST_NS / CLK_PERIOD_NS));

  // receive tolerance around each idle length, in cycles
  localparam int IDLE_TOL_CYC = 3;

  // consecutive pairs needed before a sequence is reported
  localparam int COM_VALID_REPEAT = 4;

  // bursts sent per transmitted sequence
  localparam int TX_BURST_COUNT = 6;

  // width of phase and idle counters
  localparam int CNT_W = 8;

  // undecoded ten-bit comma pattern
  localparam logic [9:0] COMMA_RAW = 10'h0fa;

  // sequence kinds requested by the fabric
  typedef enum logic [1:0] {
    COM_WAKE,
    COM_INIT,
    COM_RESET
  } com_kind_e;

  // true when a measured idle falls inside the window around a nominal length
  function automatic logic idle_in_window(input logic [CNT_W-1:0] cnt, input int nominal);
    return (int'(cnt) >= nominal - IDLE_TOL_CYC) && (int'(cnt) <= nominal + IDLE_TOL_CYC);
  endfunction

endpackage

// ==== logic/oob_seq_if.sv ====
// request and status bundle between the top and the transmit sequencer
`timescale 1ns/100ps
interface oob_seq_if;
  import oob_pkg::*;

  logic      start;
  com_kind_e kind;
  logic      busy;
  logic      burst;
  logic      done;

  modport seq (input start, input kind, output busy, output burst, output done);
  modport ctl (output start, output kind, input busy, input burst, input done);
endinterface

// ==== logic/oob_tx_seq.sv ====
// transmit sequencer: bursts and timed idles for wake, init and reset
`timescale 1ns/100ps
module oob_tx_seq (
  input  wire logic clk_sys_i,
  input  wire logic rst_b_i,
  oob_seq_if.seq    seq_if
);
  import oob_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_BURST, S_GAP} seq_state_e;

  seq_state_e        state_r;
  com_kind_e         kind_r;
  logic [CNT_W-1:0]  phase_cnt_r;
  logic [3:0]        rep_r;
  logic              done_r;
  logic [CNT_W-1:0]  gap_last;

  // RULE3: wake idle length
  // RULE4: init and reset share one idle
  assign gap_last = (kind_r == COM_WAKE) ? CNT_W'(WAKE_IDLE_CYC - 1)
                                          : CNT_W'(COM_IDLE_CYC - 1);

  // RULE1: fixed burst then idle
  // RULE6: transmit timing machine
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      state_r     <= S_IDLE;
      kind_r      <= COM_WAKE;
      phase_cnt_r <= '0;
      rep_r       <= '0;
    end else begin
      case (state_r)
        S_IDLE: begin
          phase_cnt_r <= '0;
          rep_r       <= '0;
          if (seq_if.start) begin
            kind_r  <= seq_if.kind;
            state_r <= S_BURST;
          end
        end
        S_BURST: begin
          if (phase_cnt_r == CNT_W'(BURST_CYC - 1)) begin
            phase_cnt_r <= '0;
            state_r     <= S_GAP;
          end else begin
            phase_cnt_r <= phase_cnt_r + 1'b1;
          end
        end
        S_GAP: begin
          if (phase_cnt_r == gap_last) begin
            phase_cnt_r <= '0;
            if (rep_r == 4'(TX_BURST_COUNT - 1)) begin
              state_r <= S_IDLE;
            end else begin
              rep_r   <= rep_r + 1'b1;
              state_r <= S_BURST;
            end
          end else begin
            phase_cnt_r <= phase_cnt_r + 1'b1;
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  // completion pulse in the cycle after the last idle cycle of the last burst
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      done_r <= 1'b0;
    end else begin
      done_r <= (state_r == S_GAP) && (phase_cnt_r == gap_last)
                && (rep_r == 4'(TX_BURST_COUNT - 1));
    end
  end

  assign seq_if.busy  = (state_r != S_IDLE);
  assign seq_if.burst = (state_r == S_BURST);
  assign seq_if.done  = done_r;

endmodule // oob_tx_seq

// ==== verification/oob_com_sequence_beacon_properties.sv ====
// port assertions for the out-of-band sequence block
`timescale 1ns/100ps
module oob_com_sequence_beacon_properties (
  input wire logic               clk_sys_i,
  input wire logic               rst_b_i,
  input wire logic               tx_com_start_i,
  input wire oob_pkg::com_kind_e tx_com_kind_i,
  input wire logic               tx_elec_idle_i,
  input wire logic               tx_elec_idle_o,
  input wire logic               tx_com_burst_o,
  input wire logic               tx_com_busy_o,
  input wire logic               tx_com_done_o,
  input wire logic               rx_elec_idle_i,
  input wire logic [9:0]         rx_data_raw_i,
  input wire logic               rx_elec_idle_o,
  input wire logic               rx_comwake_o,
  input wire logic               rx_cominit_o,
  input wire logic               rx_comma_o
);
  import oob_pkg::*;
  logic [CNT_W-1:0] gap_r;
  com_kind_e        kind_r;
  int               exp_gap;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  // gap so far; cleared by burst so a stuck counter shows at once
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i || tx_com_burst_o || !tx_com_busy_o) begin
      gap_r <= '0;
    end else begin
      gap_r <= gap_r + 1'b1;
    end
  end
  // kind taken with the start, two edges before busy shows
  always_ff @(posedge clk_sys_i) begin
    if ($rose(tx_com_busy_o)) begin
      kind_r <= com_kind_e'($past(tx_com_kind_i, 2));
    end
  end
  assign exp_gap = (kind_r == COM_WAKE) ? WAKE_IDLE_CYC : COM_IDLE_CYC;
  sequence burst_run;
    tx_com_burst_o [*8] ##1 tx_com_burst_o [*3] ##1 !tx_com_burst_o;
  endsequence
  burst_len_a:
    assert property ($rose(tx_com_burst_o) |-> burst_run)
    else $error("burst length wrong");
  gap_len_a:
    assert property ($rose(tx_com_burst_o) && $past(tx_com_busy_o) |-> gap_r == exp_gap)
    else $error("gap length wrong");
  last_gap_a:
    assert property (tx_com_done_o |-> gap_r == exp_gap)
    else $error("final gap wrong");
  start_answer_a:
    assert property ($rose(tx_com_busy_o) |-> tx_com_burst_o && $past(tx_com_start_i, 2))
    else $error("busy without start");
  done_pulse_a:
    assert property (tx_com_done_o |-> $fell(tx_com_busy_o) ##1 !tx_com_done_o)
    else $error("done pulse wrong");
  idle_drive_a:
    assert property (tx_com_busy_o |-> tx_elec_idle_o == !tx_com_burst_o)
    else $error("line idle wrong in sequence");
  idle_follow_a:
    assert property (!tx_com_busy_o && !$past(tx_com_busy_o) && !$past(tx_com_start_i)
      && !$past(tx_com_start_i, 2) && $past(rst_b_i) |-> tx_elec_idle_o == $past(tx_elec_idle_i))
    else $error("idle request not followed");
  comma_match_a:
    assert property ($past(rst_b_i) |-> rx_comma_o == ($past(rx_data_raw_i) == COMMA_RAW))
    else $error("comma flag wrong");
  rx_idle_follow_a:
    assert property ($past(rst_b_i, 3) |-> rx_elec_idle_o == $past(rx_elec_idle_i, 3))
    else $error("idle status not followed");
endmodule // oob_com_sequence_beacon_properties

bind oob_com_sequence_beacon oob_com_sequence_beacon_properties u_props (.*);

// ==== verification/oob_link_model.sv ====
// far-end link model driving squelch bursts and idles
`timescale 1ns/100ps
module oob_link_model (
  input  wire logic clk_sys_i,
  output logic      rx_idle_o
);
  // quiet line until the first burst
  initial rx_idle_o = 1'b1;
  task automatic pair(input int gap);
    repeat (5) @(posedge clk_sys_i) rx_idle_o <= 1'b0;
    repeat (gap) @(posedge clk_sys_i) rx_idle_o <= 1'b1;
  endtask
endmodule // oob_link_model

// ==== verification/oob_com_sequence_beacon_bench.sv ====
// self-checking bench for the out-of-band sequence block
`timescale 1ns/100ps
module oob_com_sequence_beacon_bench;
  import oob_pkg::*;
  logic       clk_sys_i = 1'b0;
  logic       rst_b_i = 1'b0;
  logic       tx_com_start_i = 1'b0;
  logic       tx_elec_idle_i = 1'b1;
  com_kind_e  tx_com_kind_i = COM_WAKE;
  logic [9:0] rx_data_raw_i = '0;
  logic [9:0] word;
  logic       rx_elec_idle_i, tx_elec_idle_o, tx_com_burst_o, tx_com_busy_o, tx_com_done_o;
  logic       rx_elec_idle_o, rx_comwake_o, rx_cominit_o, rx_comma_o, last_b;
  int         failures = 0, comparisons = 0, bursts = 0, gap = 0;
  int         tx_q[$];
  logic [1:0] rx_q[$];
  logic       comma_q[$];

  always #5 clk_sys_i = ~clk_sys_i;
  oob_com_sequence_beacon u_dut (.*);
  oob_link_model u_link (.clk_sys_i(clk_sys_i), .rx_idle_o(rx_elec_idle_i));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %0t %s: %0h not %0h", $time, what, seen, exp);
    end
  endtask
  task automatic results();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic send(input int n, input int gp);
    repeat (n) u_link.pair(gp);
  endtask

  // random raw words, many of them commas, and random idle requests
  // comma beacon bursts
  always @(posedge clk_sys_i) begin
    if (rst_b_i) begin
      word = ($urandom_range(0, 2) == 0) ? COMMA_RAW : 10'($urandom);
      rx_data_raw_i <= word;
      comma_q.push_back(word == COMMA_RAW);
      tx_elec_idle_i <= 1'($urandom);
    end
  end

  // monitor at the falling edge, where outputs have settled
  always @(negedge clk_sys_i) begin
    if (rst_b_i) begin
      if (comma_q.size() > 1) check(rx_comma_o, comma_q.pop_front(), "comma");
      if ((rx_comwake_o | rx_cominit_o) !== 1'b0) check({rx_cominit_o, rx_comwake_o}, rx_q.pop_front(), "rx");
      if (tx_com_busy_o === 1'b1 && tx_com_burst_o === 1'b0) gap++;
      if (tx_com_burst_o === 1'b1 && last_b === 1'b0) begin
        bursts++;
        if (gap > 0) check(gap, tx_q[0], "gap");
        gap = 0;
      end
      if (tx_com_done_o === 1'b1) begin
        check(gap, tx_q.pop_front(), "last gap");
        check(bursts, TX_BURST_COUNT, "bursts");
        gap = 0;
        bursts = 0;
      end
      last_b = tx_com_burst_o;
    end
  end

  // watchdog: the tests need about 1500 cycles
  initial begin
    #200000;
    failures++;
    results();
  end

  initial begin
    void'($urandom(32'h8478b37e));
    repeat (3) @(posedge clk_sys_i);
    check({tx_elec_idle_o, rx_elec_idle_o, tx_com_burst_o, tx_com_busy_o, tx_com_done_o,
      rx_comwake_o, rx_cominit_o, rx_comma_o}, 8'hc0, "reset");
    rst_b_i <= 1'b1;
    // every kind, with a refused start in mid-sequence
    for (int k = 0; k < 3; k++) begin
      tx_q.push_back(k == 0 ? WAKE_IDLE_CYC : COM_IDLE_CYC);
      tx_com_kind_i <= com_kind_e'(k);
      tx_com_start_i <= 1'b1;
      @(posedge clk_sys_i) tx_com_start_i <= 1'b0;
      repeat (5) @(posedge clk_sys_i);
      tx_com_start_i <= 1'b1;
      @(posedge clk_sys_i) tx_com_start_i <= 1'b0;
      for (int i = 0; i < 400 && tx_com_done_o !== 1'b1; i++) @(negedge clk_sys_i);
      check(tx_com_done_o, 1, "done");
      @(posedge clk_sys_i);
    end
    // wake runs, three pairs then a bad idle before the second
    rx_q.push_back(2'b01);
    send(4, WAKE_IDLE_CYC);
    repeat (60) @(posedge clk_sys_i);
    send(3, WAKE_IDLE_CYC);
    send(1, 20);
    rx_q.push_back(2'b01);
    send(4, WAKE_IDLE_CYC);
    repeat (60) @(posedge clk_sys_i);
    // shared idle timing, random within tolerance
    rx_q.push_back(2'b10);
    repeat (4) u_link.pair(COM_IDLE_CYC - IDLE_TOL_CYC + $urandom_range(0, 6));
    repeat (60) @(posedge clk_sys_i);
    // three pairs alone, then a kind change
    send(3, WAKE_IDLE_CYC);
    repeat (60) @(posedge clk_sys_i);
    send(2, COM_IDLE_CYC);
    rx_q.push_back(2'b01);
    send(4, WAKE_IDLE_CYC);
    repeat (60) @(posedge clk_sys_i);
    check(rx_q.size() + tx_q.size(), 0, "notes left");
    results();
  end
endmodule // oob_com_sequence_beacon_bench
